// ===== hdl/psdsb_bank.v
// Purpose: diagnostic status bank of the power stages
// Assumes: fault inputs come from analog comparators, asynchronous
// Notes: index n of the stage vectors is output n+1
//
// Functional notes
// [R1] group select resets to one, bridge mode
// [R2] select zero gives independent stages 21-28
// [R3] standard code: ground 00 open 01 battery 10
// [R4] register a holds outputs 4..1
// [R5] register b holds outputs 8..5
// [R6] register c: 14, 13, watchdog level, 9
// [R7] register d holds outputs 18..15
// [R8] register e: ones on top, 20, 19
// [R9] reading a diagnostic register clears it
// [R10] diagnostic registers decoded at fixed addresses
// [R11] register f single: 23,21 swapped codes
// [R12] register g single: 26,25 swapped codes
// [R13] bridge mode shows 8-bit bridge codes
// [R14] bridge code values as defined
// [R15] no undefined bridge code ever produced
// [R16] low-battery enables force independent stages
// [R17] writes to diagnostic registers are ignored
// [R18] persisting fault relatches after a read
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "psdsb_defines.vh"

module psdsb_bank
(
   input wire core_clk,
   input wire sys_rst,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [27:0] short_to_ground,
   input wire [27:0] open_load,
   input wire [27:0] short_to_battery,
   input wire [5:0] first_bridge_event,
   input wire [5:0] second_bridge_event,
   input wire watchdog_output_pin,
   output wire bridge_mode,
   output wire irq
);

   // ==========================================================
   // input synchronisers
   reg [27:0] gnd_meta;
   reg [27:0] gnd_sync;
   reg [27:0] open_meta;
   reg [27:0] open_sync;
   reg [27:0] bat_meta;
   reg [27:0] bat_sync;
   reg [5:0] br1_meta;
   reg [5:0] br1_sync;
   reg [5:0] br2_meta;
   reg [5:0] br2_sync;
   reg wdg_meta;
   reg watchdog_pin_level;

   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gnd_meta <= 28'h0000000;
         gnd_sync <= 28'h0000000;
         open_meta <= 28'h0000000;
         open_sync <= 28'h0000000;
         bat_meta <= 28'h0000000;
         bat_sync <= 28'h0000000;
         br1_meta <= 6'h00;
         br1_sync <= 6'h00;
         br2_meta <= 6'h00;
         br2_sync <= 6'h00;
         wdg_meta <= 1'b0;
         watchdog_pin_level <= 1'b0;
      end
      else
      begin
         gnd_meta <= short_to_ground;
         gnd_sync <= gnd_meta;
         open_meta <= open_load;
         open_sync <= open_meta;
         bat_meta <= short_to_battery;
         bat_sync <= bat_meta;
         br1_meta <= first_bridge_event;
         br1_sync <= br1_meta;
         br2_meta <= second_bridge_event;
         br2_sync <= br2_meta;
         wdg_meta <= watchdog_output_pin;
         watchdog_pin_level <= wdg_meta;
      end
   end

   // ==========================================================
   // software registers
   reg [7:0] stage_group_config;
   reg [1:0] low_battery_config;
   reg [6:0] irq_status;
   reg [6:0] irq_mask;

   wire stage_group_select;
   wire low_battery_enable_21;
   wire low_battery_enable_25;
   wire wr_group;
   wire wr_low_bat;
   wire wr_status;
   wire wr_mask;

   assign stage_group_select = stage_group_config[`PSDSB_GROUP_SEL_BIT];
   assign low_battery_enable_21 = low_battery_config[`PSDSB_LB21_BIT];
   assign low_battery_enable_25 = low_battery_config[`PSDSB_LB25_BIT];
   assign wr_group = reg_wr && (reg_addr == `PSDSB_ADDR_GROUP_CFG);
   assign wr_low_bat = reg_wr && (reg_addr == `PSDSB_ADDR_LOW_BAT);
   assign wr_status = reg_wr && (reg_addr == `PSDSB_ADDR_IRQ_STATUS);
   assign wr_mask = reg_wr && (reg_addr == `PSDSB_ADDR_IRQ_MASK);

   // either low-battery enable overrides the select bit
   assign bridge_mode = stage_group_select && !low_battery_enable_21 &&
      !low_battery_enable_25; // R16 R2

   // only the writable registers decode writes; the fault registers have
   // no write path at all
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stage_group_config <= `PSDSB_GROUP_CFG_RESET; // R1
         low_battery_config <= 2'h0;
         irq_mask <= 7'h00;
      end
      else
      begin
         if (wr_group)
         begin
            stage_group_config <= reg_wdata;
         end
         if (wr_low_bat)
         begin
            low_battery_config <= reg_wdata[1:0];
         end
         if (wr_mask)
         begin
            irq_mask <= reg_wdata[6:0];
         end
      end
   end

   // ==========================================================
   // read decode, one clear strobe per diagnostic register
   wire [6:0] rd_hit;

   assign rd_hit[0] = reg_rd && (reg_addr == `PSDSB_ADDR_FAULT_A); // R10
   assign rd_hit[1] = reg_rd && (reg_addr == `PSDSB_ADDR_FAULT_B); // R10
   assign rd_hit[2] = reg_rd && (reg_addr == `PSDSB_ADDR_FAULT_C); // R10
   assign rd_hit[3] = reg_rd && (reg_addr == `PSDSB_ADDR_FAULT_D); // R10
   assign rd_hit[4] = reg_rd && (reg_addr == `PSDSB_ADDR_FAULT_E); // R10
   assign rd_hit[5] = reg_rd && (reg_addr == `PSDSB_ADDR_CFG_FIRST);
   assign rd_hit[6] = reg_rd && (reg_addr == `PSDSB_ADDR_CFG_SECOND);

   // ==========================================================
   // per-stage fault fields
   wire [55:0] stage_live;
   wire [55:0] stage_held;
   wire [27:0] stage_fault;

   genvar g;
   generate
      for (g = 0; g < 28; g = g + 1)
      begin : stage
         // outputs 21, 23, 25 and 26 report battery and ground swapped
         localparam SWAP = (g == 20) || (g == 22) || (g == 24) || (g == 25);
         localparam CFG = (g >= 20);
         localparam RIX = (g < 4) ? 0 : (g < 8) ? 1 : (g < 14) ? 2 :
            (g < 18) ? 3 : (g < 20) ? 4 : (g < 24) ? 5 : 6;
         if ((g < 9) || (g > 11))
         begin : used
            reg [1:0] live;
            always @*
            begin
               live = `PSDSB_CODE_OK;
               if (CFG && bridge_mode)
               begin
                  live = `PSDSB_CODE_OK;
               end
               else if (bat_sync[g])
               begin
                  live = SWAP ? `PSDSB_SWP_BAT : `PSDSB_STD_BAT; // R3 R11 R12
               end
               else if (gnd_sync[g])
               begin
                  live = SWAP ? `PSDSB_SWP_GND : `PSDSB_STD_GND; // R3 R11 R12
               end
               else if (open_sync[g])
               begin
                  live = `PSDSB_STD_OPEN; // R3
               end
            end
            assign stage_live[2*g+1:2*g] = live;
            assign stage_fault[g] = (live != `PSDSB_CODE_OK);
            psdsb_fault_latch #(.W(2)) u_latch
            (
               .core_clk(core_clk),
               .sys_rst(sys_rst),
               .present_code(live),
               .clear(rd_hit[RIX]), // R9
               .held_code(stage_held[2*g+1:2*g])
            );
         end
         else
         begin : spare
            assign stage_live[2*g+1:2*g] = `PSDSB_CODE_OK;
            assign stage_held[2*g+1:2*g] = `PSDSB_CODE_OK;
            assign stage_fault[g] = 1'b0;
         end
      end
   endgenerate

   // ==========================================================
   // bridge codes
   // event bits: 0 ground off, 1 battery off, 2 open off,
   // 3 open on, 4 overcurrent on, 5 check running
   function [7:0] bridge_code;
      input [5:0] ev;
      begin
         // the encoder can only return the listed values
         if (ev[4])
         begin
            bridge_code = `PSDSB_BR_OVC_ON; // R14 R15
         end
         else if (ev[0])
         begin
            bridge_code = `PSDSB_BR_GND_OFF; // R14
         end
         else if (ev[1])
         begin
            bridge_code = `PSDSB_BR_BAT_OFF; // R14
         end
         else if (ev[3])
         begin
            bridge_code = `PSDSB_BR_OPEN_ON; // R14
         end
         else if (ev[2])
         begin
            bridge_code = `PSDSB_BR_OPEN_OFF; // R14
         end
         else if (ev[5])
         begin
            bridge_code = `PSDSB_BR_RUNNING; // R14
         end
         else
         begin
            bridge_code = `PSDSB_BR_OK; // R14
         end
      end
   endfunction

   wire [7:0] first_bridge_live;
   wire [7:0] second_bridge_live;
   wire [7:0] first_bridge_code;
   wire [7:0] second_bridge_code;

   assign first_bridge_live = bridge_mode ? bridge_code(br1_sync) : `PSDSB_BR_OK;
   assign second_bridge_live = bridge_mode ? bridge_code(br2_sync) : `PSDSB_BR_OK;

   psdsb_fault_latch #(.W(8)) u_first_bridge
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .present_code(first_bridge_live),
      .clear(rd_hit[5]), // R9
      .held_code(first_bridge_code)
   );

   psdsb_fault_latch #(.W(8)) u_second_bridge
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .present_code(second_bridge_live),
      .clear(rd_hit[6]), // R9
      .held_code(second_bridge_code)
   );

   // ==========================================================
   // register images
   wire [7:0] low_stage_fault_a;
   wire [7:0] low_stage_fault_b;
   wire [7:0] low_stage_fault_c;
   wire [7:0] low_stage_fault_d;
   wire [7:0] low_stage_fault_e;
   wire [7:0] config_stage_fault_first;
   wire [7:0] config_stage_fault_second;

   assign low_stage_fault_a = stage_held[7:0]; // R4
   assign low_stage_fault_b = stage_held[15:8]; // R5
   // watchdog level is live, never latched
   assign low_stage_fault_c = {stage_held[27:24], watchdog_pin_level, 1'b0,
      stage_held[17:16]}; // R6
   assign low_stage_fault_d = stage_held[35:28]; // R7
   assign low_stage_fault_e = {`PSDSB_FAULT_E_TOP, stage_held[39:36]}; // R8
   // the image follows the mode at read time
   assign config_stage_fault_first = bridge_mode ? first_bridge_code :
      stage_held[47:40]; // R13 R11
   assign config_stage_fault_second = bridge_mode ? second_bridge_code :
      stage_held[55:48]; // R13 R12

   // ==========================================================
   // interrupts: one bit per diagnostic register
   wire [6:0] irq_event;

   assign irq_event[0] = |stage_fault[3:0];
   assign irq_event[1] = |stage_fault[7:4];
   assign irq_event[2] = stage_fault[8] | stage_fault[12] | stage_fault[13];
   assign irq_event[3] = |stage_fault[17:14];
   assign irq_event[4] = |stage_fault[19:18];
   assign irq_event[5] = (|stage_fault[23:20]) |
      (first_bridge_live != `PSDSB_BR_OK);
   assign irq_event[6] = (|stage_fault[27:24]) |
      (second_bridge_live != `PSDSB_BR_OK);

   // set wins over a write-one clear in the same cycle
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         irq_status <= 7'h00;
      end
      else
      begin
         irq_status <= (irq_status & ~(wr_status ? reg_wdata[6:0] : 7'h00)) |
            irq_event;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ==========================================================
   // read data, one cycle after the strobe
   reg [7:0] next_rdata;

   always @*
   begin
      next_rdata = 8'h00;
      case (reg_addr)
         `PSDSB_ADDR_FAULT_A:
         begin
            next_rdata = low_stage_fault_a;
         end
         `PSDSB_ADDR_FAULT_B:
         begin
            next_rdata = low_stage_fault_b;
         end
         `PSDSB_ADDR_FAULT_C:
         begin
            next_rdata = low_stage_fault_c;
         end
         `PSDSB_ADDR_FAULT_D:
         begin
            next_rdata = low_stage_fault_d;
         end
         `PSDSB_ADDR_FAULT_E:
         begin
            next_rdata = low_stage_fault_e;
         end
         `PSDSB_ADDR_CFG_FIRST:
         begin
            next_rdata = config_stage_fault_first;
         end
         `PSDSB_ADDR_CFG_SECOND:
         begin
            next_rdata = config_stage_fault_second;
         end
         `PSDSB_ADDR_GROUP_CFG:
         begin
            next_rdata = stage_group_config;
         end
         `PSDSB_ADDR_LOW_BAT:
         begin
            next_rdata = {6'h00, low_battery_config};
         end
         `PSDSB_ADDR_IRQ_STATUS:
         begin
            next_rdata = {1'b0, irq_status};
         end
         `PSDSB_ADDR_IRQ_MASK:
         begin
            next_rdata = {1'b0, irq_mask};
         end
         default:
         begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // data holds only in the cycle after a read; zero otherwise
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd)
      begin
         reg_rdata <= next_rdata; // R17
      end
      else
      begin
         reg_rdata <= 8'h00;
      end
   end

   // ==========================================================
   // spare inputs: outputs 10 to 12 have no field in this bank
   wire spare_unused;

   assign spare_unused = &{stage_live[23:18], 1'b0};

endmodule // psdsb_bank

`default_nettype wire

// ===== hdl/psdsb_defines.vh
// Purpose: constants of the power-stage diagnostic status bank
// Assumes: 4-bit register address, 8-bit register data
// Notes: included by every design file of the bank
`ifndef PSDSB_DEFINES_VH
`define PSDSB_DEFINES_VH

// ==========================================================
// register addresses
`define PSDSB_ADDR_FAULT_A 4'h1
`define PSDSB_ADDR_FAULT_E 4'h2
`define PSDSB_ADDR_FAULT_B 4'h5
`define PSDSB_ADDR_CFG_FIRST 4'h6
`define PSDSB_ADDR_FAULT_C 4'h9
`define PSDSB_ADDR_CFG_SECOND 4'hA
`define PSDSB_ADDR_FAULT_D 4'hD
`define PSDSB_ADDR_GROUP_CFG 4'h3
`define PSDSB_ADDR_LOW_BAT 4'h4
`define PSDSB_ADDR_IRQ_STATUS 4'h8
`define PSDSB_ADDR_IRQ_MASK 4'hC

// ==========================================================
// reset values and field positions
`define PSDSB_GROUP_CFG_RESET 8'h01
`define PSDSB_GROUP_SEL_BIT 0
`define PSDSB_LB21_BIT 0
`define PSDSB_LB25_BIT 1
`define PSDSB_WDG_BIT 3
`define PSDSB_FAULT_E_TOP 4'hF

// ==========================================================
// 2-bit stage codes
`define PSDSB_STD_GND 2'h0
`define PSDSB_STD_OPEN 2'h1
`define PSDSB_STD_BAT 2'h2
`define PSDSB_CODE_OK 2'h3
`define PSDSB_SWP_BAT 2'h0
`define PSDSB_SWP_GND 2'h2

// ==========================================================
// 8-bit bridge codes
`define PSDSB_BR_GND_OFF 8'h01
`define PSDSB_BR_BAT_OFF 8'h05
`define PSDSB_BR_OPEN_OFF 8'h04
`define PSDSB_BR_OPEN_ON 8'h02
`define PSDSB_BR_OVC_ON 8'h03
`define PSDSB_BR_RUNNING 8'h07
`define PSDSB_BR_OK 8'hFF

`endif

// ===== hdl/psdsb_fault_latch.v
// Purpose: one clear-on-read fault field
// Assumes: ok code is all ones, any other code is a fault
// Notes: first fault since the last clear is held
`timescale 1ns/1ns
`default_nettype none
`include "psdsb_defines.vh"

module psdsb_fault_latch
#(
   parameter W = 2
)
(
   input wire core_clk,
   input wire sys_rst,
   input wire [W-1:0] present_code,
   input wire clear,
   output reg [W-1:0] held_code
);

   localparam [W-1:0] OK_CODE = {W{1'b1}};

   reg [W-1:0] next_held_code;

   // ==========================================================
   // latch
   always @*
   begin
      next_held_code = held_code;
      // a clear reloads from the live condition, so a fault seen in the
      // clearing cycle or still present is not lost
      if (clear)
      begin
         next_held_code = present_code; // R18
      end
      else if (held_code == OK_CODE)
      begin
         next_held_code = present_code;
      end
   end

   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         held_code <= OK_CODE;
      end
      else
      begin
         held_code <= next_held_code;
      end
   end

endmodule // psdsb_fault_latch

`default_nettype wire

// ===== tb/psdsb_bank_properties.sv
// Purpose: port-level checks of the diagnostic status bank
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to psdsb_bank after the module
`timescale 1ns/1ns
`default_nettype none
module psdsb_bank_properties
(
   input wire core_clk,
   input wire sys_rst,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [27:0] short_to_ground,
   input wire [27:0] open_load,
   input wire [27:0] short_to_battery,
   input wire watchdog_output_pin,
   input wire bridge_mode,
   input wire irq
);
   // true while no stage of the first register sees any fault
   wire clean_a = ~|{short_to_ground[3:0], open_load[3:0], short_to_battery[3:0]};
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // ========
   // assertions
   reset_bridge_a: assert property ($fell(sys_rst) |-> bridge_mode)
      else $error("bridge mode low after reset");
   select_single_a: assert property (
      reg_wr && reg_addr == 4'h3 && !reg_wdata[0] |=> !bridge_mode)
      else $error("select zero kept bridge mode");
   low_bat_override_a: assert property (
      reg_wr && reg_addr == 4'h4 && |reg_wdata[1:0] |=> !bridge_mode)
      else $error("low-battery enable kept bridge mode");
   unmapped_zero_a: assert property (
      reg_rd && reg_addr inside {4'h0, 4'h7, 4'hB, 4'hE, 4'hF} |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   reg_e_top_a: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:4] == 4'hF)
      else $error("top nibble of register e not ones");
   reg_c_spare_a: assert property (reg_rd && reg_addr == 4'h9 |=> !reg_rdata[2])
      else $error("unused bit of register c set");
   watchdog_live_a: assert property (
      watchdog_output_pin [*4] ##0 (reg_rd && reg_addr == 4'h9) |=> reg_rdata[3])
      else $error("watchdog level not shown");
   bridge_code_a: assert property (
      bridge_mode && reg_rd && reg_addr inside {4'h6, 4'hA}
      |=> reg_rdata inside {8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07, 8'hFF})
      else $error("undefined bridge code");
   clear_read_a: assert property (
      clean_a [*5] ##0 (reg_rd && reg_addr == 4'h1) ##1
      (reg_rd && reg_addr == 4'h1 && clean_a) |=> reg_rdata == 8'hFF)
      else $error("fault survived a clearing read");
   cover property (bridge_mode && reg_rd && reg_addr == 4'h6);
   cover property (!bridge_mode && reg_rd && reg_addr == 4'hA);
   cover property (irq);
endmodule // psdsb_bank_properties
bind psdsb_bank psdsb_bank_properties psdsb_bank_properties_i
(
   .core_clk,
   .sys_rst,
   .reg_addr,
   .reg_wdata,
   .reg_wr,
   .reg_rd,
   .reg_rdata,
   .short_to_ground,
   .open_load,
   .short_to_battery,
   .watchdog_output_pin,
   .bridge_mode,
   .irq
);
`default_nettype wire

// ===== tb/psdsb_host_model.sv
// Purpose: register-bus master standing in for the engine controller
// Assumes: tasks are called one at a time by the bench
// Notes: strobes change only by nonblocking assignment after a rising edge
`timescale 1ns/1ns
`default_nettype none
module psdsb_host_model
(
   input wire logic core_clk,
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so take it mid-cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   // two reads with no gap: the second sees what the first left behind
   task automatic rd2(input logic [3:0] a, output logic [7:0] d1, output logic [7:0] d2);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      @(negedge core_clk);
      d1 = reg_rdata;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d2 = reg_rdata;
   endtask
endmodule // psdsb_host_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the diagnostic status bank
// Assumes: 50 MHz clock, fault levels settle three edges after a change
// Notes: fault vector packs ground, open, battery, bridge one, bridge two
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic core_clk;
   logic sys_rst;
   logic [95:0] flt;
   logic wdp;
   wire logic [3:0] reg_addr;
   wire logic [7:0] reg_wdata;
   wire logic reg_wr;
   wire logic reg_rd;
   wire logic [7:0] reg_rdata;
   wire logic bridge_mode;
   wire logic irq;
   int n_fail = 0;
   int checks = 0;
   logic [3:0] a;
   int p;
   logic [7:0] bs;
   int sn [9] = '{20, 76, 21, 78, 79, 24, 81, 54, 27};
   logic [7:0] sf [9] = '{8'hFE, 8'hFC, 8'hF3, 8'hCF, 8'hBF, 8'hFE, 8'hF3, 8'hDF, 8'h3F};
   logic [7:0] bc [6] = '{8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07};
   logic [3:0] um [5] = '{4'h0, 4'h7, 4'hB, 4'hE, 4'hF};
   logic [3:0] dg [7] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA, 4'hD};
   psdsb_host_model psdsb_host_model_i
   (
      .core_clk(core_clk),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata)
   );
   psdsb_bank psdsb_bank_i
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .short_to_ground(flt[27:0]),
      .open_load(flt[55:28]),
      .short_to_battery(flt[83:56]),
      .first_bridge_event(flt[89:84]),
      .second_bridge_event(flt[95:90]),
      .watchdog_output_pin(wdp),
      .bridge_mode(bridge_mode),
      .irq(irq)
   );
   // ========
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic rc(input logic [3:0] ad, input logic [7:0] e);
      logic [7:0] d;
      psdsb_host_model_i.rd(ad, d);
      check(d, e);
   endtask
   // irq in bit 1, bridge_mode in bit 0
   task automatic cm(input logic [7:0] e);
      @(negedge core_clk);
      check({6'h00, irq, bridge_mode}, e);
   endtask
   // fault seen, then relatched once after removal, then gone
   task automatic probe(input int n, input logic [3:0] ad, input logic [7:0] f,
      input logic [7:0] b);
      logic [7:0] d1;
      logic [7:0] d2;
      @(posedge core_clk);
      flt <= 96'h1 << n;
      repeat (5) @(posedge core_clk);
      rc(ad, f);
      @(posedge core_clk);
      flt <= '0;
      repeat (5) @(posedge core_clk);
      psdsb_host_model_i.rd2(ad, d1, d2);
      check(d1, f);
      check(d2, b);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ========
   // clock, reset, sequence
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      #200000;
      n_fail++;
      summarize();
   end
   initial
   begin
      sys_rst = 1'b1;
      flt = '0;
      wdp = 1'b0;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      cm(8'h01);
      rc(4'h3, 8'h01);
      rc(4'h4, 8'h00);
      rc(4'hC, 8'h00);
      $display("test reset done");
      for (int t = 0; t < 3; t++)
         for (int i = 0; i < 20; i++)
            if (i < 9 || i > 11)
            begin
               a = (i < 4) ? 4'h1 : (i < 8) ? 4'h5 : (i < 14) ? 4'h9 : (i < 18) ? 4'hD : 4'h2;
               p = (i == 12) ? 2 : (i == 13) ? 3 : (i < 8) ? i % 4 : (i < 14) ? 0 : (i - 14) % 4;
               bs = (a == 4'h9) ? 8'hF3 : 8'hFF;
               probe(t * 28 + i, a,
                  (bs & ~(8'h03 << (2 * p))) | 8'(t << (2 * p)), bs);
            end
      $display("test stage codes done");
      for (int b = 0; b < 6; b++)
      begin
         probe(84 + b, 4'h6, bc[b], 8'hFF);
         probe(90 + b, 4'hA, bc[b], 8'hFF);
      end
      $display("test bridge codes done");
      psdsb_host_model_i.wr(4'h3, 8'h00);
      cm(8'h00);
      for (int k = 0; k < 9; k++)
         probe(sn[k], (k < 5) ? 4'h6 : 4'hA, sf[k], 8'hFF);
      $display("test single stages done");
      // a mask bit of one lets its status bit through to irq
      psdsb_host_model_i.wr(4'h8, 8'h7F);
      psdsb_host_model_i.wr(4'hC, 8'h7E);
      @(posedge core_clk);
      flt <= 96'h1;
      repeat (5) @(posedge core_clk);
      cm(8'h00);
      psdsb_host_model_i.wr(4'hC, 8'h7F);
      cm(8'h02);
      rc(4'h8, 8'h01);
      @(posedge core_clk);
      flt <= '0;
      repeat (5) @(posedge core_clk);
      cm(8'h02);
      psdsb_host_model_i.wr(4'h8, 8'h01);
      cm(8'h00);
      rc(4'h1, 8'hFC);
      $display("test interrupt done");
      psdsb_host_model_i.wr(4'h3, 8'h01);
      cm(8'h01);
      psdsb_host_model_i.wr(4'h4, 8'h01);
      cm(8'h00);
      psdsb_host_model_i.wr(4'h4, 8'h02);
      cm(8'h00);
      rc(4'h4, 8'h02);
      psdsb_host_model_i.wr(4'h4, 8'h00);
      cm(8'h01);
      $display("test group select done");
      for (int k = 0; k < 7; k++)
      begin
         psdsb_host_model_i.wr(dg[k], 8'h00);
         rc(dg[k], (dg[k] == 4'h9) ? 8'hF3 : 8'hFF);
      end
      for (int k = 0; k < 5; k++)
         rc(um[k], 8'h00);
      $display("test write ignore done");
      @(posedge core_clk);
      wdp <= 1'b1;
      repeat (5) @(posedge core_clk);
      rc(4'h9, 8'hFB);
      rc(4'h9, 8'hFB);
      @(posedge core_clk);
      wdp <= 1'b0;
      repeat (5) @(posedge core_clk);
      rc(4'h9, 8'hF3);
      $display("test watchdog done");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
